// [core/flash_cmd_pkg.sv]
package flash_cmd_pkg;

	// bus widths
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;

	// clock and bus timing, times in ns, sync latency in cycles
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_SETUP_NS = 10;
	localparam int T_WE_PULSE_NS = 50;
	localparam int T_READ_ACCESS_NS = 70;
	localparam int T_RECOVER_NS = 20;
	localparam int T_RESET_LOW_NS = 100;
	localparam int T_WAKE_NS = 1000;
	localparam int SYNC_LAT = 2;

	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT;
	localparam int REC_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CYC = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// command codes, low byte of the data bus
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CHIP_ERASE_SETUP = 8'h30;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROGRAM_SETUP_ALT = 8'h10;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
	localparam logic [7:0] CMD_LOCK_PERM = 8'hF1;
	localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;

	typedef enum logic [3:0] {
		OP_READ_ARRAY = 4'h0,
		OP_READ_ID = 4'h1,
		OP_READ_STATUS = 4'h2,
		OP_CLEAR_STATUS = 4'h3,
		OP_BLOCK_ERASE = 4'h4,
		OP_CHIP_ERASE = 4'h5,
		OP_PROGRAM = 4'h6,
		OP_PROGRAM_ALT = 4'h7,
		OP_SUSPEND = 4'h8,
		OP_RESUME = 4'h9,
		OP_SET_BLOCK_LOCK = 4'hA,
		OP_CLEAR_LOCKS = 4'hB,
		OP_SET_PERM_LOCK = 4'hC,
		OP_OTP_PROGRAM = 4'hD,
		OP_PLAIN_READ = 4'hE,
		OP_PULSE_RESET = 4'hF
	} op_t;

	// one bus cycle asked of the cycle engine
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_req_t;

	// flash control strobes
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} strobes_t;

endpackage

// [core/flash_bus_cycle.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle
	import flash_cmd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// cycle request
	input wire logic start,
	input wire bus_req_t req,
	output logic done,
	output logic [DATA_W-1:0] rd_data,
	// flash pins
	output strobes_t strobes,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DATA_W-1:0] dq_in
);

	typedef enum logic [3:0] {
		BC_IDLE = 4'b0001,
		BC_SETUP = 4'b0010,
		BC_STROBE = 4'b0100,
		BC_HOLD = 4'b1000
	} bc_state_t;

	bc_state_t state, next_state;
	logic [7:0] cnt, next_cnt;
	logic write, next_write;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_dq_out, next_rd_data;
	logic [DATA_W-1:0] dq_meta, dq_sync;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_write = write;
		next_addr = addr;
		next_dq_out = dq_out;
		next_rd_data = rd_data;
		case (state)
			BC_IDLE: begin
				if (start) begin
					next_state = BC_SETUP;
					next_cnt = 8'(SETUP_CYC - 1);
					next_write = req.write;
					next_addr = req.addr;
					next_dq_out = req.data;
				end
			end
			BC_SETUP: begin
				if (cnt == 8'h00) begin
					next_state = BC_STROBE;
					next_cnt = write ? 8'(WE_CYC - 1) : 8'(RD_CYC - 1);
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			BC_STROBE: begin
				if (cnt == 8'h00) begin
					next_state = BC_HOLD;
					next_cnt = 8'(REC_CYC - 1);
					// data sampled while oe and ce are both low
					if (!write) begin
						next_rd_data = dq_sync;
					end
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			BC_HOLD: begin
				if (cnt == 8'h00) begin
					next_state = BC_IDLE;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end
			default: next_state = BC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= BC_IDLE;
			cnt <= 8'h00;
			write <= 1'b0;
			addr <= '0;
			dq_out <= '0;
			rd_data <= '0;
			dq_meta <= '0;
			dq_sync <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			write <= next_write;
			addr <= next_addr;
			dq_out <= next_dq_out;
			rd_data <= next_rd_data;
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	// write strobe and read strobe are never low together
	assign strobes.ce_n = (state == BC_IDLE);
	assign strobes.we_n = !(state == BC_STROBE && write);
	assign strobes.oe_n = !(state == BC_STROBE && !write);
	assign dq_oe = write && (state != BC_IDLE);
	assign done = (state == BC_HOLD) && (cnt == 8'h00);

endmodule // flash_bus_cycle
`default_nettype wire

// [core/flash_command_interface.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_command_interface
	import flash_cmd_pkg::*;
#(
	parameter logic [7:0] SUSPEND_CODE = 8'h00
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// user requests
	input wire logic req_valid,
	input wire op_t req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_data,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	// user levels
	input wire logic protect_boot,
	output logic flash_busy,
	// flash pins
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [DATA_W-1:0] dq_in,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic reset_powerdown_n,
	output logic wp_n,
	input wire logic ready_busy_n
);

	typedef enum logic [4:0] {
		ST_RESET = 5'b00001,
		ST_WAKE = 5'b00010,
		ST_IDLE = 5'b00100,
		ST_FIRST = 5'b01000,
		ST_SECOND = 5'b10000
	} st_t;

	st_t state, next_state;
	logic [15:0] cnt, next_cnt;
	op_t op_q, next_op_q;
	logic [ADDR_W-1:0] addr_q, next_addr_q;
	logic [DATA_W-1:0] data_q, next_data_q;
	logic bc_start, next_bc_start;
	bus_req_t bc_req, next_bc_req;
	logic next_rsp_valid;
	logic [DATA_W-1:0] next_rsp_data;
	logic bc_done;
	logic [DATA_W-1:0] bc_rd_data;
	strobes_t strobes;
	logic rb_meta, rb_sync, prot_q;

	function automatic logic [7:0] first_code(input op_t op);
		case (op)
			OP_READ_ARRAY: first_code = CMD_READ_ARRAY;
			OP_READ_ID: first_code = CMD_READ_ID;
			OP_READ_STATUS: first_code = CMD_READ_STATUS;
			OP_CLEAR_STATUS: first_code = CMD_CLEAR_STATUS;
			OP_BLOCK_ERASE: first_code = CMD_ERASE_SETUP;
			OP_CHIP_ERASE: first_code = CMD_CHIP_ERASE_SETUP;
			OP_PROGRAM: first_code = CMD_PROGRAM_SETUP;
			OP_PROGRAM_ALT: first_code = CMD_PROGRAM_SETUP_ALT;
			OP_SUSPEND: first_code = SUSPEND_CODE;
			OP_RESUME: first_code = CMD_CONFIRM;
			OP_OTP_PROGRAM: first_code = CMD_OTP_SETUP;
			default: first_code = CMD_LOCK_SETUP;
		endcase
	endfunction

	function automatic logic has_second(input op_t op);
		case (op)
			OP_READ_ARRAY, OP_CLEAR_STATUS, OP_SUSPEND, OP_RESUME: has_second = 1'b0;
			default: has_second = 1'b1;
		endcase
	endfunction

	function automatic logic second_is_read(input op_t op);
		second_is_read = (op == OP_READ_ID) || (op == OP_READ_STATUS) || (op == OP_PLAIN_READ);
	endfunction

	function automatic logic [DATA_W-1:0] second_data(input op_t op, input logic [DATA_W-1:0] d);
		case (op)
			OP_PROGRAM, OP_PROGRAM_ALT, OP_OTP_PROGRAM: second_data = d;
			OP_SET_BLOCK_LOCK: second_data = {8'h00, CMD_LOCK_BLOCK};
			OP_SET_PERM_LOCK: second_data = {8'h00, CMD_LOCK_PERM};
			default: second_data = {8'h00, CMD_CONFIRM};
		endcase
	endfunction

	function automatic logic defined_code(input logic [7:0] c);
		case (c)
			CMD_READ_ARRAY, CMD_READ_ID, CMD_READ_STATUS, CMD_CLEAR_STATUS,
			CMD_ERASE_SETUP, CMD_CHIP_ERASE_SETUP, CMD_CONFIRM, CMD_PROGRAM_SETUP,
			CMD_PROGRAM_SETUP_ALT, CMD_LOCK_SETUP, CMD_OTP_SETUP, SUSPEND_CODE:
				defined_code = 1'b1;
			default: defined_code = 1'b0;
		endcase
	endfunction

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_op_q = op_q;
		next_addr_q = addr_q;
		next_data_q = data_q;
		next_bc_start = 1'b0;
		next_bc_req = bc_req;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		case (state)
			ST_RESET: begin
				// reset pin held low long enough to abort any operation
				if (cnt == 16'h0000) begin
					next_state = ST_WAKE;
					next_cnt = 16'(WAKE_CYC - 1);
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			ST_WAKE: begin
				// device comes back in read array mode
				if (cnt == 16'h0000) begin
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			ST_IDLE: begin
				if (req_valid) begin
					next_op_q = req_op;
					next_addr_q = req_addr;
					next_data_q = req_data;
					if (req_op == OP_PULSE_RESET) begin
						next_state = ST_RESET;
						next_cnt = 16'(RST_CYC - 1);
					end else if (req_op == OP_PLAIN_READ) begin
						next_state = ST_SECOND;
						next_bc_start = 1'b1;
						next_bc_req = '{write: 1'b0, addr: req_addr, data: '0};
					end else begin
						// every other operation opens with a command write, any address
						next_state = ST_FIRST;
						next_bc_start = 1'b1;
						next_bc_req = '{write: 1'b1, addr: req_addr,
							data: {8'h00, first_code(req_op)}};
					end
				end
			end
			ST_FIRST: begin
				if (bc_done) begin
					if (has_second(op_q)) begin
						// second cycle: block, program or otp address with data, or the status or identifier read
						next_state = ST_SECOND;
						next_bc_start = 1'b1;
						next_bc_req = '{write: !second_is_read(op_q), addr: addr_q,
							data: second_data(op_q, data_q)};
					end else begin
						next_state = ST_IDLE;
						next_rsp_valid = 1'b1;
					end
				end
			end
			ST_SECOND: begin
				if (bc_done) begin
					// status, identifier or array data returned from the read cycle
					next_state = ST_IDLE;
					next_rsp_valid = 1'b1;
					if (second_is_read(op_q)) begin
						next_rsp_data = bc_rd_data;
					end
				end
			end
			default: begin
				next_state = ST_RESET;
				next_cnt = 16'(RST_CYC - 1);
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_RESET;
			cnt <= 16'(RST_CYC - 1);
			op_q <= OP_READ_ARRAY;
			addr_q <= '0;
			data_q <= '0;
			bc_start <= 1'b0;
			bc_req <= '0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rb_meta <= 1'b1;
			rb_sync <= 1'b1;
			prot_q <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			op_q <= next_op_q;
			addr_q <= next_addr_q;
			data_q <= next_data_q;
			bc_start <= next_bc_start;
			bc_req <= next_bc_req;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			rb_meta <= ready_busy_n;
			rb_sync <= rb_meta;
			prot_q <= protect_boot;
		end
	end

	flash_bus_cycle u_cycle (
		.clk(clk),
		.rst(rst),
		.start(bc_start),
		.req(bc_req),
		.done(bc_done),
		.rd_data(bc_rd_data),
		.strobes(strobes),
		.addr(addr),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.dq_in(dq_in)
	);

	assign req_ready = (state == ST_IDLE);
	assign ce_n = strobes.ce_n;
	assign oe_n = strobes.oe_n;
	assign we_n = strobes.we_n;
	assign reset_powerdown_n = (state != ST_RESET);
	// boot blocks forced locked while protect is requested
	assign wp_n = !prot_q;
	// busy pin floats high through the pull-up when idle
	assign flash_busy = !rb_sync;

	property p_strobe_exclusive;
		@(posedge clk) disable iff (rst) !(!oe_n && !we_n);
	endproperty
	a_strobe_exclusive: assert property (p_strobe_exclusive) else $error("oe and we low together");

	property p_read_selected;
		@(posedge clk) disable iff (rst) !oe_n |-> !ce_n && !dq_oe;
	endproperty
	a_read_selected: assert property (p_read_selected) else $error("read strobe without select");

	property p_reset_width;
		@(posedge clk) disable iff (rst) $fell(reset_powerdown_n) |-> !reset_powerdown_n [*8];
	endproperty
	a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");

	property p_first_code;
		@(posedge clk) disable iff (rst)
			$fell(we_n) && state == ST_FIRST |-> dq_oe && dq_out == {8'h00, first_code(op_q)};
	endproperty
	a_first_code: assert property (p_first_code) else $error("wrong command code");

	property p_defined_code;
		@(posedge clk) disable iff (rst) !we_n && state == ST_FIRST |-> defined_code(dq_out[7:0]);
	endproperty
	a_defined_code: assert property (p_defined_code) else $error("reserved code written");

	property p_erase_confirm;
		@(posedge clk) disable iff (rst) $fell(we_n) && state == ST_SECOND && op_q == OP_BLOCK_ERASE
			|-> addr == addr_q && dq_out == {8'h00, CMD_CONFIRM};
	endproperty
	a_erase_confirm: assert property (p_erase_confirm) else $error("bad erase confirm");

	property p_program_data;
		@(posedge clk) disable iff (rst) !we_n && state == ST_SECOND
			&& (op_q == OP_PROGRAM || op_q == OP_PROGRAM_ALT) |-> addr == addr_q && dq_out == data_q;
	endproperty
	a_program_data: assert property (p_program_data) else $error("bad program data");

	property p_otp_data;
		@(posedge clk) disable iff (rst) !we_n && state == ST_SECOND && op_q == OP_OTP_PROGRAM
			|-> addr == addr_q && dq_out == data_q;
	endproperty
	a_otp_data: assert property (p_otp_data) else $error("bad otp write");

	property p_status_answer;
		@(posedge clk) disable iff (rst) state == ST_SECOND && bc_done && op_q == OP_READ_STATUS
			|=> rsp_valid && rsp_data == $past(bc_rd_data);
	endproperty
	a_status_answer: assert property (p_status_answer) else $error("status not returned");

endmodule // flash_command_interface
`default_nettype wire

// [test/flash_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
	import flash_cmd_pkg::*;
#(
	parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] SUSPEND_CODE = 8'h00,
	parameter bit PROGRAM_SUPPLY_HIGH = 1'b1,
	parameter int BUSY_NS = 400
)(
	// host pins
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dq,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rp_n,
	input wire logic wp_n,
	// device outputs
	output logic [DATA_W-1:0] dq_rd,
	output logic dq_drv,
	output logic rb_low
);
	logic [15:0] mem [int];
	logic [127:0] lk = '0;
	logic perm = 0;
	logic busy = 0;
	logic susp = 0;
	logic go = 0;
	logic [6:0] stat = '0;
	logic [7:0] setup = '0;
	logic [1:0] mode = '0;
	logic [15:0] val;
	function automatic logic lkd(input logic [18:0] a);
		return lk[a[18:12]] | (a[18:13] == 0 && !wp_n);
	endfunction
	// reset aborts and returns to array reads
	always @(negedge rp_n) begin
		mode = 0;
		setup = 0;
		busy = 0;
		susp = 0;
		stat = 0;
	end
	always begin
		wait (go);
		go = 0;
		busy = 1;
		#BUSY_NS;
		busy = 0;
	end
	// command decode on write strobe release
	always @(posedge we_n) if (!ce_n && rp_n) begin
		if (setup != 0) begin
			go = PROGRAM_SUPPLY_HIGH;
			mode = 2;
			if (!PROGRAM_SUPPLY_HIGH) stat[3] = 1;
			else case (setup)
				CMD_LOCK_SETUP: if (perm && dq[7:0] != CMD_LOCK_PERM) stat[1] = 1;
					else if (dq[7:0] == CMD_LOCK_BLOCK) lk[addr[18:12]] = 1;
					else if (dq[7:0] == CMD_CONFIRM) lk = '0;
					else perm = 1;
				CMD_CHIP_ERASE_SETUP: foreach (mem[k]) if (!lkd(19'(k))) mem[k] = 16'hFFFF;
				default: if (lkd(addr)) stat[1] = 1;
					else if (setup != CMD_ERASE_SETUP) mem[addr] = dq;
					else foreach (mem[k]) if (k[18:12] == addr[18:12]) mem[k] = 16'hFFFF;
			endcase
			setup = 0;
		end else case (dq[7:0])
			CMD_READ_ARRAY: if (!busy) mode = 0;
			CMD_READ_ID: mode = 1;
			CMD_READ_STATUS: mode = 2;
			CMD_CLEAR_STATUS: stat = 0;
			CMD_CONFIRM: susp = 0;
			SUSPEND_CODE: if (busy) susp = 1;
			CMD_ERASE_SETUP, CMD_CHIP_ERASE_SETUP, CMD_PROGRAM_SETUP, CMD_PROGRAM_SETUP_ALT,
			CMD_LOCK_SETUP, CMD_OTP_SETUP: setup = dq[7:0];
			default: ;
		endcase
	end
	// read path, released lines show the inverse
	always_comb begin
		dq_drv = !ce_n && !oe_n && rp_n;
		if (mode == 2 || busy) val = {8'h00, !busy, stat};
		else if (mode == 1) val = addr[1:0] == 0 ? {8'h00, MFR_ID} : addr[1:0] == 1 ?
			{8'h00, DEV_ID} : {15'h0, addr[1] & !addr[0] ? lk[addr[18:12]] : perm};
		else val = mem.exists(addr) ? mem[addr] : 16'hFFFF;
		dq_rd = dq_drv ? val : ~val;
		rb_low = busy && rp_n && !susp;
	end
endmodule // flash_dev_model
`default_nettype wire

// [test/tb_flash_command_interface.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_flash_command_interface
	import flash_cmd_pkg::*;
;
	localparam logic [7:0] MFR = 8'h5A; // arbitrary value
	localparam logic [7:0] DEV = 8'hA5; // arbitrary value
	localparam logic [16:0] W = '0;
	logic clk = 0;
	logic rst = 1;
	logic req_valid = 0;
	logic protect_boot = 0;
	op_t req_op = OP_PLAIN_READ;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_data = '0;
	logic rdy, rv, busy, dq_oe, ce_n, oe_n, we_n, rp_n, wp_n, drv, rb_low;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] rsp_data, dq_out, dq_rd;
	wire logic [DATA_W-1:0] dq_w = dq_oe ? dq_out : (drv ? dq_rd : ~dq_out);
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [16:0] notes [$];
	logic [16:0] nt;
	logic [18:0] a;
	logic [15:0] d = '0;
	op_t pg [2] = '{OP_PROGRAM, OP_PROGRAM_ALT};
	op_t er [2] = '{OP_BLOCK_ERASE, OP_CHIP_ERASE};
	initial forever #2 clk = ~clk;
	flash_command_interface dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
		.req_addr(req_addr), .req_data(req_data), .req_ready(rdy), .rsp_valid(rv),
		.rsp_data(rsp_data), .protect_boot(protect_boot), .flash_busy(busy), .addr(addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_w), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.reset_powerdown_n(rp_n), .wp_n(wp_n), .ready_busy_n(!rb_low));
	flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEV)) dev_u (.addr(addr), .dq(dq_w), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .wp_n(wp_n), .dq_rd(dq_rd), .dq_drv(drv),
		.rb_low(rb_low));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one request, noting the expected answer
	task automatic op(input op_t o, input logic [18:0] oa, input logic [16:0] n);
		int w;
		if (o != OP_PULSE_RESET) notes.push_back(n);
		req_op = o;
		req_addr = oa;
		req_data = d;
		req_valid = 1;
		while (rdy !== 1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1 req_valid = 0;
		w = 0;
		while (o != OP_PULSE_RESET && rv !== 1 && w < 300) begin
			@(posedge clk);
			#1 w++;
		end
	endtask
	task automatic idle();
		int w = 0;
		while (busy !== 0 && w < 400) begin
			@(posedge clk);
			#1 w++;
		end
	endtask
	// answer watcher
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
		if (oe_n === 0 && we_n === 0) chk(1, 0);
		if (rv === 1) begin
			if (notes.size() == 0) chk(1, 0);
			else begin
				nt = notes.pop_front();
				if (nt[16]) chk(rsp_data, nt[15:0]);
			end
		end
	end
	initial begin
		void'($urandom(32'h607cf219));
		repeat (5) @(posedge clk);
		#1 rst = 0;
		chk(rp_n, 0);
		a = {3'b001, 16'($urandom)};
		op(OP_PLAIN_READ, a, {1'b1, 16'hFFFF});
		$display("test reset defaults done");
		for (int i = 0; i < 2; i++) begin
			d = 16'($urandom);
			op(pg[i], a, W);
			chk(busy, 1);
			idle();
			chk(busy, 0);
			op(OP_READ_ARRAY, a, W);
			op(OP_PLAIN_READ, a, {1'b1, d});
			op(er[i], a ^ 19'h1, W);
			idle();
			op(OP_READ_ARRAY, 0, W);
			op(OP_PLAIN_READ, a, {1'b1, 16'hFFFF});
		end
		$display("test program and erase done");
		op(OP_READ_STATUS, a, {1'b1, 16'h0080});
		op(OP_READ_ID, 19'h0, {9'h100, MFR});
		op(OP_PLAIN_READ, 19'h1, {9'h100, DEV});
		$display("test status and identifier done");
		protect_boot = 1;
		d = 16'($urandom);
		op(OP_PROGRAM, 19'h100, W);
		idle();
		op(OP_READ_STATUS, 0, {1'b1, 16'h0082});
		op(OP_CLEAR_STATUS, 0, W);
		protect_boot = 0;
		op(OP_PROGRAM, 19'h100, W);
		idle();
		op(OP_READ_ARRAY, 0, W);
		op(OP_PLAIN_READ, 19'h100, {1'b1, d});
		$display("test boot protect done");
		op(OP_SET_BLOCK_LOCK, 19'h4000, W);
		idle();
		op(OP_PROGRAM, 19'h4000, W);
		idle();
		op(OP_READ_STATUS, 0, {1'b1, 16'h0082});
		op(OP_CLEAR_STATUS, 0, W);
		op(OP_READ_ID, 19'h4002, {1'b1, 16'h0001});
		op(OP_CLEAR_LOCKS, 0, W);
		idle();
		op(OP_READ_ID, 19'h4002, {1'b1, 16'h0000});
		op(OP_SET_BLOCK_LOCK, 19'h4000, W);
		idle();
		op(OP_SET_PERM_LOCK, 0, W);
		idle();
		op(OP_CLEAR_LOCKS, 0, W);
		idle();
		op(OP_READ_ID, 19'h4002, {1'b1, 16'h0001});
		$display("test lock bits done");
		d = 16'($urandom);
		op(OP_PROGRAM, a ^ 19'h4, W);
		op(OP_SUSPEND, 0, W);
		chk(busy, 0);
		op(OP_RESUME, 0, W);
		chk(busy, 1);
		idle();
		$display("test suspend resume done");
		op(OP_PROGRAM, a, W);
		op(OP_PULSE_RESET, 0, W);
		repeat (5) @(posedge clk);
		#1 chk(busy, 0);
		op(OP_PLAIN_READ, a ^ 19'h2, {1'b1, 16'hFFFF});
		op(OP_READ_ID, 19'h3, {1'b1, 16'h0001});
		$display("test reset abort done");
		close_out();
	end
endmodule // tb_flash_command_interface
`default_nettype wire
